// File: rtl/acc_sat_pkg.sv
// Constants for the accumulator saturation, rounding and write-back block.
// Assumes a 16-bit core with two 40-bit accumulators and a 20 MHz clock.
package acc_sat_pkg;
  localparam int ACC_W   = 40;
  localparam int WORD_W  = 16;
  localparam int REG_AW  = 4;

  // Saturation values
  localparam logic [39:0] SAT40_POS = 40'h7fffffffff;
  localparam logic [39:0] SAT40_NEG = 40'h8000000000;
  localparam logic [39:0] SAT32_POS = 40'h007fffffff;
  localparam logic [39:0] SAT32_NEG = 40'hff80000000;

  // Bit positions, rounding half, write-back step and word limits
  localparam int BIT_SIGN40 = 39;
  localparam int BIT_SIGN32 = 31;
  localparam int HI_LSB     = 16;
  localparam int LO_MSB     = 15;
  localparam logic [15:0] LO_HALF = 16'h8000;
  localparam logic [15:0] WB_STEP = 16'h0002;
  localparam logic [15:0] WORD_MAX = 16'h7fff;
  localparam logic [15:0] WORD_MIN = 16'h8000;

  // Register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK   = 4'h2;
  localparam logic [3:0] REG_WBPTR  = 4'h3;
  localparam logic [3:0] REG_ACCA_L = 4'h4;
  localparam logic [3:0] REG_ACCA_H = 4'h5;
  localparam logic [3:0] REG_ACCA_U = 4'h6;
  localparam logic [3:0] REG_ACCB_L = 4'h7;
  localparam logic [3:0] REG_ACCB_H = 4'h8;
  localparam logic [3:0] REG_ACCB_U = 4'h9;
  localparam logic [3:0] REG_EVENT  = 4'ha;

  // Control bits
  localparam int CTRL_SAT_EN  = 0;
  localparam int CTRL_SAT40   = 1;
  localparam int CTRL_ROUND   = 2;
  localparam int CTRL_COVTRAP = 3;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // Status bits
  localparam int ST_A_SAT = 0;
  localparam int ST_B_SAT = 1;
  localparam int ST_A_OVF = 2;
  localparam int ST_B_OVF = 3;
  localparam int ST_ANY_OVF = 4;
  localparam int ST_ANY_SAT = 5;

  // Event bits (interrupt sources)
  localparam int EV_SAT  = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_WB   = 2;
  localparam int EV_W    = 3;

  typedef enum logic [2:0] {
    OP_ADD, OP_STORE_TRUNC, OP_STORE_RND, OP_MAC, OP_MUL_ONLY, OP_MUL_NEG, OP_DIST, OP_DIST_ACC
  } acc_op_t;

  typedef enum logic [1:0] {WB_NONE, WB_DIRECT, WB_INDIRECT} wb_mode_t;
endpackage

// File: rtl/acc_sat_round.sv
// Saturation, overflow flags, rounding and write-back for two 40-bit accumulators.
// Assumes one-cycle op strobes from the decoder and a one-cycle register port.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module acc_sat_round
  import acc_sat_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              op_valid,
  input  wire acc_op_t           op_code,
  input  wire logic              op_target_b,
  input  wire logic [ACC_W-1:0]  op_operand,
  input  wire logic              op_subtract,
  input  wire wb_mode_t          op_wb_mode,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [WORD_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [WORD_W-1:0]      reg_rdata,
  output logic                   xbus_wr,
  output logic [WORD_W-1:0]      xbus_addr,
  output logic [WORD_W-1:0]      xbus_wdata,
  output logic                   trap_req,
  output logic                   irq
);

  typedef struct packed {
    logic [ACC_W-1:0]  acc_a;
    logic [ACC_W-1:0]  acc_b;
    logic [WORD_W-1:0] ctrl;
    logic              acc_a_sat_flag;
    logic              acc_b_sat_flag;
    logic              acc_a_ovf_flag;
    logic              acc_b_ovf_flag;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   mask;
    logic [WORD_W-1:0] writeback_pointer_reg;
    logic              xwr;
    logic [WORD_W-1:0] xaddr;
    logic [WORD_W-1:0] xdata;
    logic [WORD_W-1:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Rounded or truncated upper word, then write saturation to 1.15
  function automatic logic [WORD_W-1:0] store_word(input logic [ACC_W-1:0] acc,
                                                   input logic round_en,
                                                   input logic convergent);
    logic [15:0] lo;
    logic        inc;
    logic [ACC_W-1:0] r;
    begin
      lo  = acc[LO_MSB:0];
      inc = 1'b0;
      if (round_en) begin
        inc = acc[LO_MSB];
        if (convergent && lo == LO_HALF) begin
          inc = acc[HI_LSB];
        end
      end
      r = acc + {23'h0, inc, 16'h0};
      // Write saturation: value outside 1.15 range clamps
      if (!r[BIT_SIGN40] && r[BIT_SIGN40-1:BIT_SIGN32] != 8'h00) begin
        store_word = WORD_MAX;
      end else if (r[BIT_SIGN40] && r[BIT_SIGN40-1:BIT_SIGN32] != 8'hff) begin
        store_word = WORD_MIN;
      end else begin
        store_word = r[BIT_SIGN32:HI_LSB];
      end
    end
  endfunction

  function automatic logic [WORD_W-1:0] ctrl_bits(input state_t s);
    begin
      ctrl_bits = s.ctrl;
    end
  endfunction

  logic [ACC_W:0]    sum;
  logic [ACC_W-1:0]  tgt;
  logic [ACC_W-1:0]  res;
  logic              ovf39;
  logic              ovf31;
  logic              sat_en;
  logic              sat40;
  logic              ovf_hit;
  logic              ovf_flag;
  logic [WORD_W-1:0] wb_word;
  logic [WORD_W-1:0] st_word;
  logic [WORD_W-1:0] status_w;
  logic [EV_W-1:0]   ev_set;
  logic              is_add;
  logic              mac_wb;

  always_comb begin
    s_d     = s_q;
    sat_en  = s_q.ctrl[CTRL_SAT_EN];
    sat40   = s_q.ctrl[CTRL_SAT40];
    tgt     = op_target_b ? s_q.acc_b : s_q.acc_a;
    is_add  = op_valid && (op_code == OP_ADD || op_code == OP_MAC || op_code == OP_MUL_ONLY ||
              op_code == OP_MUL_NEG || op_code == OP_DIST || op_code == OP_DIST_ACC);
    if (op_code == OP_MUL_ONLY || op_code == OP_MUL_NEG || op_code == OP_DIST) begin
      sum = {op_operand[ACC_W-1], op_operand};
    end else if (op_subtract) begin
      sum = {tgt[ACC_W-1], tgt} - {op_operand[ACC_W-1], op_operand};
    end else begin
      sum = {tgt[ACC_W-1], tgt} + {op_operand[ACC_W-1], op_operand};
    end
    ovf39   = sum[ACC_W] ^ sum[BIT_SIGN40];
    // Bit 31 overflow: guard bits no longer a sign extension
    ovf31   = (sum[ACC_W:BIT_SIGN32] != {(ACC_W-BIT_SIGN32+1){1'b0}}) &&
              (sum[ACC_W:BIT_SIGN32] != {(ACC_W-BIT_SIGN32+1){1'b1}});
    res     = sum[ACC_W-1:0];
    ovf_hit = ovf39;
    ovf_flag = ovf31;
    if (sat_en && sat40) begin
      ovf_hit = ovf39;
      if (ovf39) begin
        res = sum[ACC_W] ? SAT40_NEG : SAT40_POS;
      end
    end else if (sat_en) begin
      ovf_hit  = ovf31;
      ovf_flag = 1'b0;
      if (ovf31) begin
        res = sum[ACC_W] ? SAT32_NEG : SAT32_POS;
      end
    end
    ev_set = '0;
    if (is_add) begin
      if (op_target_b) begin
        s_d.acc_b = res;
        s_d.acc_b_ovf_flag = ovf_flag;
        if (ovf_hit) s_d.acc_b_sat_flag = 1'b1;
      end else begin
        s_d.acc_a = res;
        s_d.acc_a_ovf_flag = ovf_flag;
        if (ovf_hit) s_d.acc_a_sat_flag = 1'b1;
      end
      ev_set[EV_SAT] = ovf_hit;
    end
    // Write-back of the non-target accumulator, always rounded
    mac_wb  = op_valid && op_code == OP_MAC && op_wb_mode != WB_NONE;
    wb_word = store_word(op_target_b ? s_q.acc_a : s_q.acc_b, 1'b1,
                         s_q.ctrl[CTRL_ROUND]);
    st_word = store_word(tgt, op_code == OP_STORE_RND, s_q.ctrl[CTRL_ROUND]);
    s_d.xwr = 1'b0;
    if (op_valid && (op_code == OP_STORE_TRUNC || op_code == OP_STORE_RND)) begin
      s_d.xwr   = 1'b1;
      s_d.xaddr = s_q.writeback_pointer_reg;
      s_d.xdata = st_word;
    end else if (mac_wb) begin
      ev_set[EV_WB] = 1'b1;
      if (op_wb_mode == WB_DIRECT) begin
        s_d.writeback_pointer_reg = wb_word;
      end else begin
        s_d.xwr   = 1'b1;
        s_d.xaddr = s_q.writeback_pointer_reg;
        s_d.xdata = wb_word;
        s_d.writeback_pointer_reg = s_q.writeback_pointer_reg + WB_STEP;
      end
    end
    ev_set[EV_TRAP] = !sat_en && s_q.ctrl[CTRL_COVTRAP] &&
                      (s_q.acc_a_sat_flag || s_q.acc_b_sat_flag);
    status_w = '0;
    status_w[ST_A_SAT]   = s_q.acc_a_sat_flag;
    status_w[ST_B_SAT]   = s_q.acc_b_sat_flag;
    status_w[ST_A_OVF]   = s_q.acc_a_ovf_flag;
    status_w[ST_B_OVF]   = s_q.acc_b_ovf_flag;
    status_w[ST_ANY_OVF] = s_q.acc_a_ovf_flag | s_q.acc_b_ovf_flag;
    status_w[ST_ANY_SAT] = s_q.acc_a_sat_flag | s_q.acc_b_sat_flag;
    // Register writes; a set in the same cycle wins over the clear
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:   s_d.ctrl = reg_wdata;
        REG_STATUS: begin
          if (reg_wdata[ST_A_SAT] && !(is_add && !op_target_b && ovf_hit))
            s_d.acc_a_sat_flag = 1'b0;
          if (reg_wdata[ST_B_SAT] && !(is_add && op_target_b && ovf_hit))
            s_d.acc_b_sat_flag = 1'b0;
        end
        REG_MASK:   s_d.mask = reg_wdata[EV_W-1:0];
        REG_WBPTR:  if (!mac_wb) s_d.writeback_pointer_reg = reg_wdata;
        REG_ACCA_L: if (!is_add) s_d.acc_a[15:0] = reg_wdata;
        REG_ACCA_H: if (!is_add) s_d.acc_a[31:16] = reg_wdata;
        REG_ACCA_U: if (!is_add) s_d.acc_a[39:32] = reg_wdata[7:0];
        REG_ACCB_L: if (!is_add) s_d.acc_b[15:0] = reg_wdata;
        REG_ACCB_H: if (!is_add) s_d.acc_b[31:16] = reg_wdata;
        REG_ACCB_U: if (!is_add) s_d.acc_b[39:32] = reg_wdata[7:0];
        REG_EVENT:  s_d.ev = s_q.ev & ~reg_wdata[EV_W-1:0];
        default: ;
      endcase
    end
    s_d.ev = s_d.ev | ev_set;
    s_d.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:   s_d.rdata = ctrl_bits(s_q);
        REG_STATUS: s_d.rdata = status_w;
        REG_MASK:   s_d.rdata = {{(WORD_W-EV_W){1'b0}}, s_q.mask};
        REG_WBPTR:  s_d.rdata = s_q.writeback_pointer_reg;
        REG_ACCA_L: s_d.rdata = s_q.acc_a[15:0];
        REG_ACCA_H: s_d.rdata = s_q.acc_a[31:16];
        REG_ACCA_U: s_d.rdata = {8'h00, s_q.acc_a[39:32]};
        REG_ACCB_L: s_d.rdata = s_q.acc_b[15:0];
        REG_ACCB_H: s_d.rdata = s_q.acc_b[31:16];
        REG_ACCB_U: s_d.rdata = {8'h00, s_q.acc_b[39:32]};
        REG_EVENT:  s_d.rdata = {{(WORD_W-EV_W){1'b0}}, s_q.ev};
        default:    s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata  = s_q.rdata;
  assign xbus_wr    = s_q.xwr;
  assign xbus_addr  = s_q.xaddr;
  assign xbus_wdata = s_q.xdata;
  // Level trap request while condition holds
  assign trap_req   = !s_q.ctrl[CTRL_SAT_EN] && s_q.ctrl[CTRL_COVTRAP] &&
                      (s_q.acc_a_sat_flag || s_q.acc_b_sat_flag);
  assign irq        = |(s_q.ev & s_q.mask);
endmodule
`default_nettype wire

// File: verification/acc_sat_round_properties.sv
// Port-level properties of the accumulator saturation and write-back block.
// Assumes it is bound to acc_sat_round and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module acc_sat_round_props
  import acc_sat_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              op_valid,
  input wire acc_op_t           op_code,
  input wire wb_mode_t          op_wb_mode,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [WORD_W-1:0] reg_rdata,
  input wire logic              xbus_wr,
  input wire logic [WORD_W-1:0] xbus_addr,
  input wire logic              trap_req
);
  logic [3:0] ctrl_q;
  logic       mac_ind;
  logic       is_store;
  assign mac_ind  = op_valid && op_code == OP_MAC && op_wb_mode == WB_INDIRECT;
  assign is_store = op_valid && (op_code == OP_STORE_TRUNC || op_code == OP_STORE_RND);
  // Software view of the control bits, kept apart from the design's copy
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      ctrl_q <= 4'h0;
    else if (reg_wr && reg_addr == REG_CTRL)
      ctrl_q <= reg_wdata[3:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_store_writes: assert property (is_store |=> xbus_wr)
    else $error("store gave no bus write");
  chk_mac_writes: assert property (mac_ind |=> xbus_wr)
    else $error("write-back gave no bus write");
  chk_write_cause: assert property (xbus_wr |-> $past(is_store || mac_ind))
    else $error("bus write without a cause");
  chk_direct_silent: assert property (
    op_valid && op_code == OP_MAC && op_wb_mode == WB_DIRECT |=> !xbus_wr)
    else $error("direct write-back used the bus");
  chk_ptr_step: assert property (
    mac_ind ##1 mac_ind |=> xbus_addr == $past(xbus_addr) + WB_STEP)
    else $error("pointer did not step by two");
  chk_trap_cause: assert property (trap_req |-> !ctrl_q[CTRL_SAT_EN] && ctrl_q[CTRL_COVTRAP])
    else $error("trap outside its mode");
  chk_status_or: assert property ($past(reg_rd && reg_addr == REG_STATUS) |->
    reg_rdata[ST_ANY_SAT] == (reg_rdata[ST_A_SAT] | reg_rdata[ST_B_SAT]) &&
    reg_rdata[ST_ANY_OVF] == (reg_rdata[ST_A_OVF] | reg_rdata[ST_B_OVF]))
    else $error("combined status bits wrong");
  chk_ctrl_readback: assert property ($past(reg_rd && reg_addr == REG_CTRL) |->
    reg_rdata[3:0] == $past(ctrl_q))
    else $error("control bits read back wrong");
  cover property (mac_ind ##1 mac_ind);
  cover property (trap_req);
  cover property (is_store ##1 xbus_wr);
endmodule
`default_nettype wire

// File: verification/data_space_model.sv
// Data-space memory behind the X write bus.
// Assumes word writes at even addresses, one word per xbus_wr pulse.
`timescale 1ns/100ps
`default_nettype none
module data_space_model (
  input wire logic        clk_sys,
  input wire logic        xbus_wr,
  input wire logic [15:0] xbus_addr,
  input wire logic [15:0] xbus_wdata
);
  // Only 256 words kept, upper address bits alias
  logic [15:0] mem [256];
  always_ff @(posedge clk_sys) begin
    if (xbus_wr)
      mem[xbus_addr[8:1]] <= xbus_wdata;
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench: register port, op strobes and the X write bus.
// Assumes the package, design, checker and data-space model compile first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import acc_sat_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_target_b = 1'b0;
  logic op_subtract = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, xbus_wr, trap_req, irq;
  acc_op_t           op_code = OP_ADD;
  wb_mode_t          op_wb_mode = WB_NONE;
  logic [ACC_W-1:0]  op_operand = '0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [WORD_W-1:0] reg_wdata = '0, reg_rdata, xbus_addr, xbus_wdata;
  int                fails = 0;
  int                n_tests = 0;
  // High word, low word, conventional result, convergent result
  logic [15:0] rt [5][4] = '{'{16'h1234, 16'h7fff, 16'h1234, 16'h1234},
    '{16'h1234, 16'h8000, 16'h1235, 16'h1234}, '{16'h1234, 16'h8001, 16'h1235, 16'h1235},
    '{16'h1235, 16'h8000, 16'h1236, 16'h1236}, '{16'h7fff, 16'h8000, 16'h7fff, 16'h7fff}};
  always #25 clk_sys = ~clk_sys;
  acc_sat_round u_dut (.clk_sys, .sys_rst, .op_valid, .op_code, .op_target_b, .op_operand,
    .op_subtract, .op_wb_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .xbus_wr, .xbus_addr, .xbus_wdata, .trap_req, .irq);
  data_space_model u_mem (.clk_sys, .xbus_wr, .xbus_addr, .xbus_wdata);
  task automatic conclude();
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Tasks start and end on a rising edge; the gap cycle avoids double drives
  task automatic wr(logic [3:0] a, logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  task automatic setacc(logic b, logic [39:0] v);
    logic [3:0] a;
    a = b ? REG_ACCB_L : REG_ACCA_L;
    wr(a, v[15:0]);
    wr(a + 4'h1, v[31:16]);
    wr(a + 4'h2, {8'h00, v[39:32]});
  endtask
  task automatic op(acc_op_t c, logic b, logic [39:0] v, logic s, wb_mode_t m,
                    logic hold, logic ew, logic [15:0] ed);
    op_code <= c;
    op_target_b <= b;
    op_operand <= v;
    op_subtract <= s;
    op_wb_mode <= m;
    op_valid <= 1'b1;
    @(posedge clk_sys);
    if (!hold) begin
      op_valid <= 1'b0;
      #1 check("xbus_wr", 16'(xbus_wr), 16'(ew));
      if (ew)
        check("xbus_wdata", xbus_wdata, ed);
      @(posedge clk_sys);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(REG_CTRL, 16'h0000);
    rd(REG_STATUS, 16'h0000);
    wr(REG_CTRL, 16'h0003);
    setacc(0, 40'h7fffffffff);
    op(OP_ADD, 0, 40'h1, 0, WB_NONE, 0, 0, 0);
    rd(REG_ACCA_H, 16'hffff);
    op(OP_STORE_TRUNC, 0, '0, 0, WB_NONE, 0, 1, 16'h7fff);
    setacc(1, 40'h8000000000);
    op(OP_ADD, 1, 40'h1, 1, WB_NONE, 0, 0, 0);
    rd(REG_ACCB_H, 16'h0000);
    rd(REG_STATUS, 16'h003f);
    wr(REG_CTRL, 16'h0001);
    wr(REG_STATUS, 16'h0003);
    setacc(0, 40'h007fffffff);
    op(OP_ADD, 0, 40'h1, 0, WB_NONE, 0, 0, 0);
    rd(REG_ACCA_H, 16'h7fff);
    setacc(1, 40'hff80000000);
    op(OP_ADD, 1, 40'h1, 1, WB_NONE, 0, 0, 0);
    rd(REG_ACCB_H, 16'h8000);
    rd(REG_STATUS, 16'h0023);
    op(OP_ADD, 0, '0, 0, WB_NONE, 0, 0, 0);
    rd(REG_STATUS, 16'h0023);
    wr(REG_STATUS, 16'h0001);
    rd(REG_STATUS, 16'h0022);
    wr(REG_CTRL, 16'h0008);
    wr(REG_STATUS, 16'h0003);
    setacc(0, 40'h7fffffffff);
    op(OP_ADD, 0, 40'h1, 0, WB_NONE, 0, 0, 0);
    rd(REG_ACCA_H, 16'h0000);
    rd(REG_STATUS, 16'h0035);
    check("trap_req", 16'(trap_req), 16'h0001);
    check("irq", 16'(irq), 16'h0000);
    wr(REG_MASK, 16'h0001);
    check("irq", 16'(irq), 16'h0001);
    wr(REG_EVENT, 16'h000f);
    check("irq", 16'(irq), 16'h0000);
    wr(REG_CTRL, 16'h0009);
    check("trap_req", 16'(trap_req), 16'h0000);
    wr(REG_WBPTR, 16'h0040);
    for (int r = 0; r < 2; r++) begin
      wr(REG_CTRL, 16'(r << CTRL_ROUND));
      for (int i = 0; i < 5; i++) begin
        setacc(0, {8'h00, rt[i][0], rt[i][1]});
        op(OP_STORE_RND, 0, '0, 0, WB_NONE, 0, 1, rt[i][2 + r]);
        op(OP_STORE_TRUNC, 0, '0, 0, WB_NONE, 0, 1, rt[i][0]);
      end
    end
    check("xbus_addr", xbus_addr, 16'h0040);
    wr(REG_CTRL, 16'h0000);
    setacc(1, 40'h0040008000);
    wr(REG_WBPTR, 16'h0100);
    op(OP_MAC, 0, '0, 0, WB_INDIRECT, 1, 0, 0);
    op(OP_MAC, 0, '0, 0, WB_INDIRECT, 0, 1, 16'h4001);
    check("xbus_addr", xbus_addr, 16'h0102);
    check("mem", u_mem.mem[8'h80], 16'h4001);
    rd(REG_WBPTR, 16'h0104);
    op(OP_MAC, 0, '0, 0, WB_DIRECT, 0, 0, 0);
    rd(REG_WBPTR, 16'h4001);
    for (int i = 4; i < 8; i++)
      op(acc_op_t'(i), 0, '0, 0, WB_INDIRECT, 0, 0, 0);
    conclude();
  end
  initial begin
    #(5000 * 50);
    fails++;
    conclude();
  end
endmodule
bind acc_sat_round acc_sat_round_props u_props (.clk_sys, .sys_rst, .op_valid, .op_code,
  .op_wb_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .xbus_wr, .xbus_addr,
  .trap_req);
`default_nettype wire
